// [include/sdc_pkg.sv]
package sdc_pkg;
  // ----------------------------------------
  // Register select codes
  // ----------------------------------------
  localparam logic [3:0] SDC_SEL_INT = 4'h0;
  localparam logic [3:0] SDC_SEL_FRAC = 4'h1;
  localparam logic [3:0] SDC_SEL_AUX = 4'h2;
  localparam logic [3:0] SDC_SEL_PHASE = 4'h3;
  localparam logic [3:0] SDC_SEL_REF = 4'h4;
  localparam logic [3:0] SDC_SEL_OUTDIV = 4'h6;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SDC_SEL_LSB = 0;
  localparam int SDC_AUTOCAL_BIT = 21;
  localparam int SDC_PRESC_BIT = 20;
  localparam int SDC_INT_LSB = 4;
  localparam int SDC_INT_W = 16;
  localparam int SDC_FRAC_LSB = 4;
  localparam int SDC_FRAC_W = 24;
  localparam int SDC_AUXMOD_LSB = 4;
  localparam int SDC_AUXFRAC_LSB = 18;
  localparam int SDC_AUX_W = 14;
  localparam int SDC_SDINH_BIT = 30;
  localparam int SDC_RESYNC_BIT = 29;
  localparam int SDC_PADJ_BIT = 28;
  localparam int SDC_PHASE_LSB = 4;
  localparam int SDC_PHASE_W = 24;
  localparam int SDC_MUX_LSB = 27;
  localparam int SDC_MUX_W = 3;
  localparam int SDC_DBL_BIT = 26;
  localparam int SDC_HALF_BIT = 25;
  localparam int SDC_RDIV_LSB = 15;
  localparam int SDC_RDIV_W = 10;
  localparam int SDC_DBUF_BIT = 14;
  localparam int SDC_CP_LSB = 10;
  localparam int SDC_CP_W = 4;
  localparam int SDC_OUTDIV_LSB = 21;
  localparam int SDC_OUTDIV_W = 3;
  // ----------------------------------------
  // Reset values and calibration length
  // ----------------------------------------
  localparam logic [SDC_RDIV_W-1:0] SDC_RDIV_RST = 10'h001;
  localparam logic [SDC_AUX_W-1:0] SDC_AUXMOD_RST = 14'h0002;
  localparam int SDC_CAL_CYCLES = 16;
endpackage

// [hdl/sdc_sync2.sv]
`timescale 1ns/1ns
module sdc_sync2 (
  sys_clk,
  nrst,
  din,
  dout
);
  input wire logic sys_clk;
  input wire logic nrst;
  input wire logic din;
  output logic dout;
  logic s1_q;
  logic s2_q;
  logic s1_d;
  logic s2_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule

// [hdl/sdc_ref_div.sv]
`timescale 1ns/1ns
module sdc_ref_div
  import sdc_pkg::*;
#(
  parameter int W = SDC_RDIV_W
) (
  sys_clk,
  nrst,
  ref_edge,
  ratio,
  halve,
  pfd_tick,
  pfd_ref
);
  input wire logic sys_clk;
  input wire logic nrst;
  input wire logic ref_edge;
  input wire logic [W-1:0] ratio;
  input wire logic halve;
  output logic pfd_tick;
  output logic pfd_ref;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tog_q;
  logic tog_d;
  logic tick_q;
  logic tick_d;
  logic hit;

  // ----------------------------------------
  // Divide by ratio, toggle stage optionally halves tick
  // ----------------------------------------
  always_comb begin
    hit = ref_edge && (cnt_q + W'(1) >= ratio);
    cnt_d = cnt_q;
    tog_d = tog_q;
    tick_d = 1'b0;
    if (ref_edge) begin
      cnt_d = hit ? '0 : cnt_q + W'(1); // RULE21
    end
    if (hit) begin
      tog_d = ~tog_q; // RULE20
      tick_d = halve ? tog_q : 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tog_q <= tog_d;
      tick_q <= tick_d;
    end
  end

  assign pfd_tick = tick_q;
  assign pfd_ref = tog_q;
endmodule

// [hdl/sdc_regs.sv]
`timescale 1ns/1ns
// How it works
// RULE1 - Low four bits pick target register
// RULE2 - Host writes zero to word-0 reserved bits
// RULE3 - Autocal set: word-0 write starts calibration
// RULE4 - Autocal clear: word-0 write keeps band
// RULE5 - Host disables autocal only when appropriate
// RULE6 - Bit 20 selects prescaler; integer minimums
// RULE7 - Host keeps integer within prescaler range
// RULE8 - Word 1 holds 24-bit main fraction
// RULE9 - Host keeps aux fraction below modulus
// RULE10 - Host keeps aux modulus 2 to 16383
// RULE11 - Shadowed fields apply on word-0 write
// RULE12 - Word-0 write resets modulator unless inhibited
// RULE13 - Resync needs reset enabled, aux zero
// RULE14 - Phase adjust: word-0 write advances phase
// RULE15 - Phase step is value over 2^24 turn
// RULE16 - Host never enables resync with adjust
// RULE17 - Word 4 bits 29:27 select mux source
// RULE18 - Host avoids divider outputs while retuning
// RULE19 - Doubler makes both reference edges active
// RULE20 - Halver toggle stage gives 50% duty
// RULE21 - Reference divider divides by 1 to 1023
// RULE22 - Word-4 bit 14 shadows output divider
// RULE23 - Serial word latched on load enable
// RULE24 - Reserved bits ignored, not stored
module sdc_regs
  import sdc_pkg::*;
#(
  parameter int CAL_CYCLES = SDC_CAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  input wire logic ref_in,
  output logic autocal_busy,
  output logic autocal_start,
  output logic prescaler_or_resync_bit,
  output logic [SDC_INT_W-1:0] int_value,
  output logic [SDC_FRAC_W-1:0] main_fraction,
  output logic [SDC_AUX_W-1:0] aux_fraction,
  output logic [SDC_AUX_W-1:0] aux_modulus,
  output logic modulator_reset,
  output logic phase_resync_enable,
  output logic phase_adjust_enable,
  output logic [SDC_PHASE_W-1:0] phase_accum,
  output logic [SDC_MUX_W-1:0] test_mux_output,
  output logic reference_doubler_enable,
  output logic reference_halver_enable,
  output logic [SDC_RDIV_W-1:0] ref_divide,
  output logic divider_double_buffer_enable,
  output logic [SDC_CP_W-1:0] cp_current,
  output logic [SDC_OUTDIV_W-1:0] out_divider_select,
  output logic pfd_tick,
  output logic pfd_ref
);
  typedef enum logic [0:0] {
    SDC_CAL_IDLE = 1'b0,
    SDC_CAL_RUN = 1'b1
  } sdc_cal_e;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s;
  logic sdat_s;
  logic le_s;
  logic ref_s;

  sdc_sync2 u_sync_clk (.sys_clk(sys_clk), .nrst(nrst), .din(ser_clk), .dout(sclk_s));
  sdc_sync2 u_sync_dat (.sys_clk(sys_clk), .nrst(nrst), .din(ser_data), .dout(sdat_s));
  sdc_sync2 u_sync_le (.sys_clk(sys_clk), .nrst(nrst), .din(ser_le), .dout(le_s));
  sdc_sync2 u_sync_ref (.sys_clk(sys_clk), .nrst(nrst), .din(ref_in), .dout(ref_s));

  // ----------------------------------------
  // Serial shifter and edge detection
  // ----------------------------------------
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic sclk_prev_q;
  logic le_prev_q;
  logic ref_prev_q;
  logic load;
  logic [3:0] sel;

  always_comb begin
    shift_d = shift_q;
    if (sclk_s && !sclk_prev_q) begin
      shift_d = {shift_q[30:0], sdat_s}; // RULE23
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= '0;
      sclk_prev_q <= 1'b0;
      le_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      sclk_prev_q <= sclk_s;
      le_prev_q <= le_s;
      ref_prev_q <= ref_s;
    end
  end

  assign load = le_s && !le_prev_q; // RULE23
  assign sel = shift_q[SDC_SEL_LSB +: 4];

  logic wr0;
  logic wr1;
  logic wr2;
  logic wr3;
  logic wr4;
  logic wr6;

  always_comb begin
    wr0 = 1'b0;
    wr1 = 1'b0;
    wr2 = 1'b0;
    wr3 = 1'b0;
    wr4 = 1'b0;
    wr6 = 1'b0;
    if (load && sel == SDC_SEL_INT) begin
      wr0 = 1'b1; // RULE1
    end else if (load && sel == SDC_SEL_FRAC) begin
      wr1 = 1'b1; // RULE1
    end else if (load && sel == SDC_SEL_AUX) begin
      wr2 = 1'b1; // RULE1
    end else if (load && sel == SDC_SEL_PHASE) begin
      wr3 = 1'b1; // RULE1
    end else if (load && sel == SDC_SEL_REF) begin
      wr4 = 1'b1; // RULE1
    end else if (load && sel == SDC_SEL_OUTDIV) begin
      wr6 = 1'b1;
    end
  end

  // ----------------------------------------
  // Register fields, shadow and active
  // ----------------------------------------
  logic presc_q, presc_d;
  logic [SDC_INT_W-1:0] int_q, int_d;
  logic [SDC_FRAC_W-1:0] frac_sh_q, frac_sh_d, frac_q, frac_d;
  logic [SDC_AUX_W-1:0] auxf_sh_q, auxf_sh_d, auxf_q, auxf_d;
  logic [SDC_AUX_W-1:0] auxm_sh_q, auxm_sh_d, auxm_q, auxm_d;
  logic sdinh_q, sdinh_d;
  logic resync_q, resync_d;
  logic padj_q, padj_d;
  logic [SDC_PHASE_W-1:0] phase_sh_q, phase_sh_d;
  logic [SDC_PHASE_W-1:0] acc_q, acc_d;
  logic [SDC_MUX_W-1:0] mux_q, mux_d;
  logic dbl_q, dbl_d;
  logic half_q, half_d;
  logic [SDC_RDIV_W-1:0] rdiv_q, rdiv_d;
  logic dbuf_q, dbuf_d;
  logic [SDC_CP_W-1:0] cp_q, cp_d;
  logic [SDC_OUTDIV_W-1:0] od_sh_q, od_sh_d, od_q, od_d;
  logic modrst_q, modrst_d;
  logic start_q, start_d;

  always_comb begin
    presc_d = presc_q;
    int_d = int_q;
    frac_sh_d = frac_sh_q;
    frac_d = frac_q;
    auxf_sh_d = auxf_sh_q;
    auxf_d = auxf_q;
    auxm_sh_d = auxm_sh_q;
    auxm_d = auxm_q;
    sdinh_d = sdinh_q;
    resync_d = resync_q;
    padj_d = padj_q;
    phase_sh_d = phase_sh_q;
    acc_d = acc_q;
    mux_d = mux_q;
    dbl_d = dbl_q;
    half_d = half_q;
    rdiv_d = rdiv_q;
    dbuf_d = dbuf_q;
    cp_d = cp_q;
    od_sh_d = od_sh_q;
    od_d = od_q;
    modrst_d = 1'b0;
    start_d = 1'b0;
    // Reserved bits are simply not captured
    if (wr1) begin
      frac_sh_d = shift_q[SDC_FRAC_LSB +: SDC_FRAC_W]; // RULE8 RULE24
    end
    if (wr2) begin
      auxf_sh_d = shift_q[SDC_AUXFRAC_LSB +: SDC_AUX_W];
      auxm_sh_d = shift_q[SDC_AUXMOD_LSB +: SDC_AUX_W];
    end
    if (wr3) begin
      sdinh_d = shift_q[SDC_SDINH_BIT];
      resync_d = shift_q[SDC_RESYNC_BIT];
      padj_d = shift_q[SDC_PADJ_BIT];
      phase_sh_d = shift_q[SDC_PHASE_LSB +: SDC_PHASE_W];
    end
    if (wr4) begin
      mux_d = shift_q[SDC_MUX_LSB +: SDC_MUX_W]; // RULE17
      dbl_d = shift_q[SDC_DBL_BIT];
      half_d = shift_q[SDC_HALF_BIT];
      rdiv_d = shift_q[SDC_RDIV_LSB +: SDC_RDIV_W];
      dbuf_d = shift_q[SDC_DBUF_BIT];
      cp_d = shift_q[SDC_CP_LSB +: SDC_CP_W];
    end
    if (wr6) begin
      od_sh_d = shift_q[SDC_OUTDIV_LSB +: SDC_OUTDIV_W];
      if (!dbuf_q) begin
        od_d = shift_q[SDC_OUTDIV_LSB +: SDC_OUTDIV_W]; // RULE22
      end
    end
    if (wr0) begin
      presc_d = shift_q[SDC_PRESC_BIT]; // RULE6
      int_d = shift_q[SDC_INT_LSB +: SDC_INT_W];
      frac_d = frac_sh_q; // RULE11
      auxf_d = auxf_sh_q; // RULE11
      auxm_d = auxm_sh_q; // RULE11
      if (dbuf_q) begin
        od_d = od_sh_q; // RULE22
      end
      modrst_d = !sdinh_q; // RULE12
      start_d = shift_q[SDC_AUTOCAL_BIT]; // RULE3 RULE4
      if (padj_q) begin
        acc_d = acc_q + phase_sh_q; // RULE14 RULE15
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      presc_q <= 1'b0;
      int_q <= '0;
      frac_sh_q <= '0;
      frac_q <= '0;
      auxf_sh_q <= '0;
      auxf_q <= '0;
      auxm_sh_q <= SDC_AUXMOD_RST;
      auxm_q <= SDC_AUXMOD_RST;
      sdinh_q <= 1'b0;
      resync_q <= 1'b0;
      padj_q <= 1'b0;
      phase_sh_q <= '0;
      acc_q <= '0;
      mux_q <= '0;
      dbl_q <= 1'b0;
      half_q <= 1'b0;
      rdiv_q <= SDC_RDIV_RST;
      dbuf_q <= 1'b0;
      cp_q <= '0;
      od_sh_q <= '0;
      od_q <= '0;
      modrst_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      int_q <= int_d;
      frac_sh_q <= frac_sh_d;
      frac_q <= frac_d;
      auxf_sh_q <= auxf_sh_d;
      auxf_q <= auxf_d;
      auxm_sh_q <= auxm_sh_d;
      auxm_q <= auxm_d;
      sdinh_q <= sdinh_d;
      resync_q <= resync_d;
      padj_q <= padj_d;
      phase_sh_q <= phase_sh_d;
      acc_q <= acc_d;
      mux_q <= mux_d;
      dbl_q <= dbl_d;
      half_q <= half_d;
      rdiv_q <= rdiv_d;
      dbuf_q <= dbuf_d;
      cp_q <= cp_d;
      od_sh_q <= od_sh_d;
      od_q <= od_d;
      modrst_q <= modrst_d;
      start_q <= start_d;
    end
  end

  // ----------------------------------------
  // Calibration sequencer
  // ----------------------------------------
  sdc_cal_e cal_q, cal_d;
  logic [7:0] cal_cnt_q, cal_cnt_d;

  always_comb begin
    cal_d = cal_q;
    cal_cnt_d = cal_cnt_q;
    case (cal_q)
      SDC_CAL_IDLE: begin
        if (start_q) begin
          cal_d = SDC_CAL_RUN; // RULE3
          cal_cnt_d = 8'(CAL_CYCLES - 1);
        end
      end
      SDC_CAL_RUN: begin
        if (start_q) begin
          cal_cnt_d = 8'(CAL_CYCLES - 1);
        end else if (cal_cnt_q == 8'h00) begin
          cal_d = SDC_CAL_IDLE;
        end else begin
          cal_cnt_d = cal_cnt_q - 8'h01;
        end
      end
      default: begin
        cal_d = SDC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cal_q <= SDC_CAL_IDLE;
      cal_cnt_q <= 8'h00;
    end else begin
      cal_q <= cal_d;
      cal_cnt_q <= cal_cnt_d;
    end
  end

  // ----------------------------------------
  // Reference path
  // ----------------------------------------
  logic ref_edge;

  // Falling edge only, or both edges when doubled
  assign ref_edge = dbl_q ? (ref_s ^ ref_prev_q) : (ref_prev_q && !ref_s); // RULE19

  sdc_ref_div #(.W(SDC_RDIV_W)) u_rdiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_edge(ref_edge),
    .ratio(rdiv_q),
    .halve(half_q),
    .pfd_tick(pfd_tick),
    .pfd_ref(pfd_ref)
  );

  assign autocal_busy = (cal_q == SDC_CAL_RUN);
  assign autocal_start = start_q;
  assign prescaler_or_resync_bit = presc_q;
  assign int_value = int_q;
  assign main_fraction = frac_q;
  assign aux_fraction = auxf_q;
  assign aux_modulus = auxm_q;
  assign modulator_reset = modrst_q;
  assign phase_resync_enable = resync_q;
  assign phase_adjust_enable = padj_q;
  assign phase_accum = acc_q;
  assign test_mux_output = mux_q;
  assign reference_doubler_enable = dbl_q;
  assign reference_halver_enable = half_q;
  assign ref_divide = rdiv_q;
  assign divider_double_buffer_enable = dbuf_q;
  assign cp_current = cp_q;
  assign out_divider_select = od_q;
endmodule

// [verification/sdc_regs_props.sv]
`timescale 1ns/1ns
module sdc_regs_props
  import sdc_pkg::*;
#(
  parameter int CAL_CYCLES = SDC_CAL_CYCLES
) (
  sys_clk,
  nrst,
  ser_le,
  autocal_busy,
  autocal_start,
  int_value,
  main_fraction,
  modulator_reset,
  phase_adjust_enable,
  phase_accum,
  ref_divide
);
  input wire logic sys_clk;
  input wire logic nrst;
  input wire logic ser_le;
  input wire logic autocal_busy;
  input wire logic autocal_start;
  input wire logic [SDC_INT_W-1:0] int_value;
  input wire logic [SDC_FRAC_W-1:0] main_fraction;
  input wire logic modulator_reset;
  input wire logic phase_adjust_enable;
  input wire logic [SDC_PHASE_W-1:0] phase_accum;
  input wire logic [SDC_RDIV_W-1:0] ref_divide;
  // ----------------------------------------
  // Load strobe history and busy length
  // ----------------------------------------
  logic [5:0] le_q, le_d;
  logic [8:0] busy_q, busy_d;
  logic le_recent;
  always_comb begin
    le_d = {le_q[4:0], ser_le};
    busy_d = autocal_busy ? busy_q + 9'h001 : 9'h000;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      le_q <= 6'h00;
      busy_q <= 9'h000;
    end else begin
      le_q <= le_d;
      busy_q <= busy_d;
    end
  end
  assign le_recent = |(le_q[4:1] & ~le_q[5:2]);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_start_pulse; autocal_start |=> !autocal_start; endproperty
  property p_busy_follows; autocal_start |-> ##[0:1] autocal_busy; endproperty
  property p_busy_len; busy_q <= CAL_CYCLES; endproperty
  property p_busy_cause; $rose(autocal_busy) |-> autocal_start || $past(autocal_start); endproperty
  property p_modrst_pulse; modulator_reset |=> !modulator_reset; endproperty
  property p_int_cause; !$stable(int_value) |-> le_recent; endproperty
  property p_frac_cause; !$stable(main_fraction) |-> le_recent; endproperty
  property p_ref_cause; !$stable(ref_divide) |-> le_recent; endproperty
  property p_phase_step; !$stable(phase_accum) |-> le_recent && phase_adjust_enable; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("calibration start wider than one cycle");
  a_busy_follows: assert property (p_busy_follows) else $error("calibration start without busy");
  a_busy_len: assert property (p_busy_len) else $error("calibration busy too long");
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without start");
  a_modrst_pulse: assert property (p_modrst_pulse) else $error("modulator reset wider than one cycle");
  a_int_cause: assert property (p_int_cause) else $error("integer changed without load");
  a_frac_cause: assert property (p_frac_cause) else $error("fraction changed without load");
  a_ref_cause: assert property (p_ref_cause) else $error("ref ratio changed without load");
  a_phase_step: assert property (p_phase_step) else $error("phase moved without adjust load");
  c_cal: cover property (autocal_start);
  c_mrst: cover property (modulator_reset);
  c_phase: cover property (!$stable(phase_accum));
endmodule

// [verification/sdc_host_model.sv]
`timescale 1ns/1ns
module sdc_host_model (
  sys_clk,
  ser_clk,
  ser_data,
  ser_le
);
  input wire logic sys_clk;
  output logic ser_clk;
  output logic ser_data;
  output logic ser_le;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // One word, MSB first, then load strobe
  // ----------------------------------------
  task automatic send_word(input logic [31:0] w, input int per);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      hold(per);
      ser_clk = 1'b1;
      hold(per);
      ser_clk = 1'b0;
    end
    // Released data line shows the inverse, not a held value
    ser_data = ~w[0];
    hold(per);
    ser_le = 1'b1;
    hold(per);
    ser_le = 1'b0;
    hold(per);
  endtask
endmodule

// [verification/synth_divider_control_regs_tb.sv]
`timescale 1ns/1ns
module synth_divider_control_regs_tb;
  import sdc_pkg::*;
  localparam int CALN = 8;
  logic sys_clk, nrst, ser_clk, ser_data, ser_le, ref_in, pr_q;
  logic autocal_busy, autocal_start, presc, modulator_reset, resync, padj, dbl, half, dbuf, pfd_tick, pfd_ref;
  logic [SDC_INT_W-1:0] int_value;
  logic [SDC_FRAC_W-1:0] main_fraction;
  logic [SDC_AUX_W-1:0] aux_fraction, aux_modulus;
  logic [SDC_PHASE_W-1:0] phase_accum;
  logic [SDC_MUX_W-1:0] mux;
  logic [SDC_RDIV_W-1:0] ref_divide;
  logic [SDC_CP_W-1:0] cp;
  logic [SDC_OUTDIV_W-1:0] outdiv;
  int bad_count, checks_done, n_cal, n_rst, n_busy, n_tick, n_rc, c0, r0, b0;
  sdc_host_model host (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
  sdc_regs #(.CAL_CYCLES(CALN)) dut (.sys_clk(sys_clk), .nrst(nrst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le), .ref_in(ref_in), .autocal_busy(autocal_busy), .autocal_start(autocal_start),
    .prescaler_or_resync_bit(presc), .int_value(int_value), .main_fraction(main_fraction),
    .aux_fraction(aux_fraction), .aux_modulus(aux_modulus), .modulator_reset(modulator_reset),
    .phase_resync_enable(resync), .phase_adjust_enable(padj), .phase_accum(phase_accum), .test_mux_output(mux),
    .reference_doubler_enable(dbl), .reference_halver_enable(half), .ref_divide(ref_divide),
    .divider_double_buffer_enable(dbuf), .cp_current(cp), .out_divider_select(outdiv), .pfd_tick(pfd_tick),
    .pfd_ref(pfd_ref));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    ref_in = 1'b0;
    forever begin
      repeat (3) @(posedge sys_clk);
      #1 ref_in = ~ref_in;
    end
  end
  always @(posedge sys_clk) begin
    if (autocal_start === 1'b1) n_cal++;
    if (modulator_reset === 1'b1) n_rst++;
    if (autocal_busy === 1'b1) n_busy++;
    if (pfd_tick === 1'b1) n_tick++;
    if (pfd_ref !== pr_q) n_rc++;
    pr_q <= pfd_ref;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    c0 = n_cal;
    r0 = n_rst;
    b0 = n_busy;
    host.send_word(w, 4);
    repeat (12) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(40 * 100000);
    bad_count++;
    report_and_stop;
  end
  initial begin
    nrst = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check(aux_modulus, SDC_AUXMOD_RST);
    check(ref_divide, SDC_RDIV_RST);
    check(phase_accum, 0);
    // Reference word: mux 5, doubler, halver, ratio 3, shadowing, cp a
    wr({2'b00, 3'h5, 1'b1, 1'b1, 10'd3, 1'b1, 4'ha, 6'h00, SDC_SEL_REF});
    check({mux, dbl, half, dbuf, cp}, {3'h5, 1'b1, 1'b1, 1'b1, 4'ha});
    check(ref_divide, 10'd3);
    n_tick = 0;
    n_rc = 0;
    repeat (180) @(posedge sys_clk);
    #1;
    check(n_tick >= 9 && n_tick <= 11, 1);
    check(n_rc + 2 >= 2 * n_tick && n_rc <= 2 * n_tick + 2, 1);
    // Doubler and halver off: falling edges only, tick per hit
    wr({2'b00, 3'h5, 1'b0, 1'b0, 10'd3, 1'b1, 4'ha, 6'h00, SDC_SEL_REF});
    check({mux, dbl, half, dbuf, cp}, {3'h5, 1'b0, 1'b0, 1'b1, 4'ha});
    n_tick = 0;
    n_rc = 0;
    repeat (180) @(posedge sys_clk);
    #1;
    check(n_tick >= 9 && n_tick <= 11, 1);
    check(n_rc + 1 >= n_tick && n_rc <= n_tick + 1, 1);
    // Shadowed words wait for word 0
    wr({4'h0, 24'habcdef, SDC_SEL_FRAC});
    wr({14'd3, 14'd100, SDC_SEL_AUX});
    wr({1'b0, 1'b1, 1'b0, 1'b1, 24'h100000, SDC_SEL_PHASE});
    wr({8'h00, 3'h5, 17'h0, SDC_SEL_OUTDIV});
    check({main_fraction, aux_modulus, outdiv}, {24'h0, SDC_AUXMOD_RST, 3'h0});
    check(padj, 1'b1);
    wr({10'h000, 1'b0, 1'b1, 16'd100, SDC_SEL_INT});
    check({presc, int_value}, {1'b1, 16'd100});
    check({main_fraction, aux_fraction, aux_modulus}, {24'habcdef, 14'd3, 14'd100});
    check(outdiv, 3'h5);
    check(n_cal - c0, 0);
    check(n_rst - r0, 0);
    check(phase_accum, 24'h100000);
    wr({10'h000, 1'b0, 1'b1, 16'd100, SDC_SEL_INT});
    check(phase_accum, 24'h200000);
    // Resync setup with calibration and modulator reset
    wr({14'd0, 14'd16383, SDC_SEL_AUX});
    wr({1'b0, 1'b0, 1'b1, 1'b0, 24'h000123, SDC_SEL_PHASE});
    check({resync, padj}, 2'b10);
    wr({10'h000, 1'b1, 1'b0, 16'd23, SDC_SEL_INT});
    check(n_cal - c0, 1);
    check(n_busy - b0, CALN);
    check(n_rst - r0, 1);
    check({presc, int_value, aux_fraction, aux_modulus}, {1'b0, 16'd23, 14'd0, 14'd16383});
    check(phase_accum, 24'h200000);
    // Unassigned select codes change nothing
    for (int c = 5; c < 16; c++) begin
      if (c != 6) wr({28'hfffffff, 4'(c)});
    end
    check({mux, ref_divide, cp, int_value}, {3'h5, 10'd3, 4'ha, 16'd23});
    check(outdiv, 3'h5);
    report_and_stop;
  end
endmodule
bind sdc_regs sdc_regs_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.sys_clk(sys_clk), .nrst(nrst), .ser_le(ser_le),
  .autocal_busy(autocal_busy), .autocal_start(autocal_start), .int_value(int_value), .main_fraction(main_fraction),
  .modulator_reset(modulator_reset), .phase_adjust_enable(phase_adjust_enable), .phase_accum(phase_accum),
  .ref_divide(ref_divide));
